// >>> rtl/dci_map.svh
/*
  Constants of the debug command interpreter: command bytes, register
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the interpreter design file.
*/
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH

// Command bytes
`define DCI_CMD_REV      8'h00
`define DCI_CMD_STAT_RD  8'h02
`define DCI_CMD_CTL_WR   8'h04
`define DCI_CMD_CTL_RD   8'h05
`define DCI_CMD_PC_WR    8'h06
`define DCI_CMD_PC_RD    8'h07
`define DCI_CMD_REG_WR   8'h08
`define DCI_CMD_REG_RD   8'h09

// Control register fields
`define DCI_CTL_HALT     7
`define DCI_CTL_RESET    0
`define DCI_CTL_RST_VAL  8'h00
`define DCI_CTL_WR_MASK  8'hf1

// Status register fields
`define DCI_STAT_IDLE    7
`define DCI_STAT_HALT    6
`define DCI_STAT_RPEN    5

// Fill bytes for refused reads
`define DCI_FILL_BYTE    8'hff
`define DCI_FILL_WORD    16'hffff

// Break sent back after a link error, in system clock cycles
`define DCI_BREAK_CYC    13'd4096

`endif

// >>> rtl/dci_pkg.sv
/*
  Types of the debug command interpreter: state encoding and the packed
  state record of the main module.
  Assumes dci_map.svh holds the numeric constants.
*/
package dci_pkg;

  typedef enum logic [7:0] {
    S_IDLE   = 8'b0000_0001,
    S_ARG    = 8'b0000_0010,
    S_SEND   = 8'b0000_0100,
    S_WDATA  = 8'b0000_1000,
    S_RDREQ  = 8'b0001_0000,
    S_RDWAIT = 8'b0010_0000,
    S_RDCAP  = 8'b0100_0000,
    S_RDTAKE = 8'b1000_0000
  } dci_state_t;

  typedef struct packed {
    dci_state_t  st;
    logic [7:0]  cmd;
    logic [1:0]  argn;
    logic [7:0]  hi;
    logic [11:0] addr;
    logic [8:0]  cnt;
    logic [15:0] resp;
    logic [1:0]  nresp;
    logic [7:0]  rdat;
    logic [7:0]  ctl;
    logic        push;
    logic [7:0]  push_data;
    logic        reg_wr;
    logic        reg_rd;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        pc_wr;
    logic [15:0] pc_wdata;
    logic        rx_ready;
    logic        baud_reset;
    logic [12:0] brk_cnt;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_bits;
    logic [15:0] tx_div;
    logic        pin_oe;
    logic        pin_o;
  } dci_st_t;

endpackage : dci_pkg

// >>> rtl/dci_fifo.sv
/*
  Small synchronous FIFO for response bytes, width and depth as
  parameters, valid/ready on both sides, synchronous flush.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dci_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } dci_fifo_st_t;

  dci_fifo_st_t q, d;
  logic         do_wr;
  logic         do_rd;

  // Depth must be a power of two, at least two
  if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
    $error("dci_fifo depth must be a power of two of at least two");
  end

  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (do_wr) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (do_rd) begin
      d.rp = q.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      d.cnt = q.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : dci_fifo

// >>> rtl/dci_interp.sv
/*
  Debug command interpreter: decodes command bytes from the receive
  engine, keeps the debug control register, talks to the register file
  and program counter, and serialises answers onto the open-drain pin.
  Assumes the auto-baud engine delivers whole received bytes with an
  error pulse, and supplies the bit period in system clock cycles.
*/
`timescale 1ns/1ps
`include "dci_map.svh"

// Notes on behaviour
// - In debug mode every defined command runs, bar protection limits.
// - Outside debug mode only revision, status, control write and read act.
// - Protection refuses PC write/read and register read.
// - Command 00H answers revision, major byte first then minor.
// - Command 02H answers the debug status register byte.
// - Command 04H takes one byte into the debug control register.
// - Under protection a control write may set the halt flag, never clear.
// - Command 05H answers the debug control register byte.
// - Command 06H takes PC high then low; kept only in debug, unprotected.
// - Command 07H answers PC high then low, or FFFFH when refused.
// - Register write moves 1 to 256 bytes; size zero means 256.
// - Outside debug mode register write bytes are swallowed, nothing changes.
// - Under protection only flash control registers take written data.
// - Under protection flash command register takes only the mass-erase value.
// - Command 09H answers register bytes, or FFH each when refused.
// - Register read returns 1 to 256 bytes; size zero means 256.
// - Each byte is start bit, eight data bits LSB first, stop bit.
// - On break, framing error or collision: abort, send 4096-cycle break.
module dci_interp #(
  parameter logic [15:0] REVISION   = 16'h0100,
  parameter logic [11:0] FLASH_LO   = 12'hff8,
  parameter logic [11:0] FLASH_HI   = 12'hfff,
  parameter logic [11:0] FLASH_CMD  = 12'hff8,
  parameter logic [7:0]  MASS_ERASE = 8'h63,
  parameter int          FIFO_DEPTH = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_err,
  output logic             rx_ready,
  output logic             baud_reset,
  input  wire logic [15:0] baud_div,
  input  wire logic        debug_serial_pin_i,
  output logic             debug_serial_pin_o,
  output logic             debug_serial_pin_oe,
  input  wire logic        read_protect_option,
  input  wire logic        cpu_halted,
  input  wire logic        brk_idle,
  input  wire logic        brk_halt,
  input  wire logic        reset_done,
  output logic [7:0]       debug_control_reg,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [11:0]      reg_addr,
  output logic [7:0]       reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  output logic             pc_wr_en,
  output logic [15:0]      pc_wdata,
  input  wire logic [15:0] pc_rdata
);

  dci_pkg::dci_st_t q, d;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [7:0]       fifo_out_data;
  logic             pop;
  logic             flush;
  logic             push_ok;
  logic             allowed;
  logic             rx_take;
  logic             collide;
  logic [7:0]       status;

  // Flash window must be ordered and hold the command register
  if (FLASH_LO > FLASH_HI || FLASH_CMD < FLASH_LO || FLASH_CMD > FLASH_HI) begin : g_bad_flash
    $error("dci_interp flash window parameters are inconsistent");
  end

  // Parameter bytes expected after each command
  function automatic logic [1:0] arg_count(input logic [7:0] cmd);
    unique case (cmd)
      `DCI_CMD_CTL_WR: arg_count = 2'd1;
      `DCI_CMD_PC_WR:  arg_count = 2'd2;
      `DCI_CMD_REG_WR: arg_count = 2'd3;
      `DCI_CMD_REG_RD: arg_count = 2'd3;
      default:         arg_count = 2'd0;
    endcase
  endfunction : arg_count

  // Write allowed under protection: flash window, mass erase only on command
  function automatic logic flash_ok(input logic [11:0] a, input logic [7:0] b);
    flash_ok = (a >= FLASH_LO) && (a <= FLASH_HI) && (a != FLASH_CMD || b == MASS_ERASE);
  endfunction : flash_ok

  // Size byte to byte count, zero meaning 256
  function automatic logic [8:0] size_count(input logic [7:0] s);
    size_count = (s == 8'h00) ? 9'd256 : {1'b0, s};
  endfunction : size_count

  // Shared decodes
  assign allowed = q.ctl[`DCI_CTL_HALT] && !read_protect_option;
  assign push_ok = fifo_in_ready && !q.push;
  assign rx_take = rx_valid && q.rx_ready;
  assign pop     = fifo_out_valid && (q.tx_bits == 4'd0) && (q.brk_cnt == 13'd0);
  // Collision: own bit released, yet the pin reads low at mid-bit
  assign collide = (q.tx_bits != 4'd0) && !q.pin_oe && !debug_serial_pin_i
                   && (q.tx_div == {1'b0, baud_div[15:1]});
  assign flush   = rx_err || collide;
  assign status  = {q.ctl[`DCI_CTL_HALT] | brk_idle, cpu_halted, read_protect_option, 5'h00};

  // Next-state logic
  always_comb begin
    d            = q;
    d.push       = 1'b0;
    d.reg_wr     = 1'b0;
    d.reg_rd     = 1'b0;
    d.pc_wr      = 1'b0;
    d.baud_reset = 1'b0;
    d.pin_o      = 1'b0;

    // Reset completion clears the reset bit; a host write in the same cycle wins
    if (reset_done) begin
      d.ctl[`DCI_CTL_RESET] = 1'b0;
    end

    // Command decode and parameter collection
    unique case (q.st)
      dci_pkg::S_IDLE: begin
        if (rx_take) begin
          d.cmd = rx_data;
          unique case (rx_data)
            `DCI_CMD_REV: begin
              d.resp  = REVISION;
              d.nresp = 2'd2;
              d.st    = dci_pkg::S_SEND;
            end
            `DCI_CMD_STAT_RD: begin
              d.resp  = {8'h00, status};
              d.nresp = 2'd1;
              d.st    = dci_pkg::S_SEND;
            end
            `DCI_CMD_CTL_RD: begin
              d.resp  = {8'h00, q.ctl};
              d.nresp = 2'd1;
              d.st    = dci_pkg::S_SEND;
            end
            `DCI_CMD_PC_RD: begin
              d.resp  = allowed ? pc_rdata : `DCI_FILL_WORD;
              d.nresp = 2'd2;
              d.st    = dci_pkg::S_SEND;
            end
            `DCI_CMD_CTL_WR, `DCI_CMD_PC_WR, `DCI_CMD_REG_WR, `DCI_CMD_REG_RD: begin
              d.argn = arg_count(rx_data);
              d.st   = dci_pkg::S_ARG;
            end
            default: begin
              d.st = dci_pkg::S_IDLE;
            end
          endcase
        end
      end
      dci_pkg::S_ARG: begin
        if (rx_take) begin
          d.argn = q.argn - 2'd1;
          if (q.argn == 2'd3) begin
            d.addr[11:8] = rx_data[3:0];
          end else if (q.argn == 2'd2) begin
            d.addr[7:0] = rx_data;
            d.hi        = rx_data;
          end else begin
            d.st = dci_pkg::S_IDLE;
            unique case (q.cmd)
              `DCI_CMD_CTL_WR: begin
                d.ctl = rx_data & `DCI_CTL_WR_MASK;
                if (read_protect_option) begin
                  d.ctl[`DCI_CTL_HALT] = rx_data[`DCI_CTL_HALT] | q.ctl[`DCI_CTL_HALT];
                end
              end
              `DCI_CMD_PC_WR: begin
                d.pc_wr    = allowed;
                d.pc_wdata = {q.hi, rx_data};
              end
              `DCI_CMD_REG_WR: begin
                d.cnt = size_count(rx_data);
                d.st  = dci_pkg::S_WDATA;
              end
              default: begin
                d.cnt = size_count(rx_data);
                d.st  = dci_pkg::S_RDREQ;
              end
            endcase
          end
        end
      end
      dci_pkg::S_SEND: begin
        if (push_ok) begin
          d.push      = 1'b1;
          d.push_data = (q.nresp == 2'd2) ? q.resp[15:8] : q.resp[7:0];
          d.nresp     = q.nresp - 2'd1;
          if (q.nresp == 2'd1) begin
            d.st = dci_pkg::S_IDLE;
          end
        end
      end
      dci_pkg::S_WDATA: begin
        if (rx_take) begin
          // Debug mode needed; protection narrows to flash registers
          if (q.ctl[`DCI_CTL_HALT] && (!read_protect_option || flash_ok(q.addr, rx_data))) begin
            d.reg_wr    = 1'b1;
            d.reg_addr  = q.addr;
            d.reg_wdata = rx_data;
          end
          d.addr = q.addr + 12'd1;
          d.cnt  = q.cnt - 9'd1;
          if (q.cnt == 9'd1) begin
            d.st = dci_pkg::S_IDLE;
          end
        end
      end
      dci_pkg::S_RDREQ: begin
        // Refused reads skip the register file and answer the fill byte
        if (allowed) begin
          d.reg_rd   = 1'b1;
          d.reg_addr = q.addr;
          d.st       = dci_pkg::S_RDWAIT;
        end else begin
          d.rdat = `DCI_FILL_BYTE;
          d.st   = dci_pkg::S_RDTAKE;
        end
      end
      dci_pkg::S_RDWAIT: begin
        d.st = dci_pkg::S_RDCAP;
      end
      dci_pkg::S_RDCAP: begin
        d.rdat = reg_rdata;
        d.st   = dci_pkg::S_RDTAKE;
      end
      dci_pkg::S_RDTAKE: begin
        if (push_ok) begin
          d.push      = 1'b1;
          d.push_data = q.rdat;
          d.addr      = q.addr + 12'd1;
          d.cnt       = q.cnt - 9'd1;
          d.st        = (q.cnt == 9'd1) ? dci_pkg::S_IDLE : dci_pkg::S_RDREQ;
        end
      end
    endcase

    // Breakpoint halt sets the halt flag, winning over a same-cycle host clear
    if (brk_halt) begin
      d.ctl[`DCI_CTL_HALT] = 1'b1;
    end

    // Serial transmitter and break generator
    // The next frame starts only once the stop bit has gone out
    if (q.brk_cnt != 13'd0) begin
      d.brk_cnt = q.brk_cnt - 13'd1;
      d.pin_oe  = (q.brk_cnt != 13'd1);
    end else if (q.tx_bits != 4'd0) begin
      if (q.tx_div == 16'd0) begin
        d.tx_div  = baud_div - 16'd1;
        d.pin_oe  = !q.tx_sh[0];
        d.tx_sh   = {1'b1, q.tx_sh[9:1]};
        d.tx_bits = q.tx_bits - 4'd1;
      end else begin
        d.tx_div = q.tx_div - 16'd1;
      end
    end else if (pop) begin
      d.pin_oe  = 1'b1;
      d.tx_sh   = {2'b11, fifo_out_data};
      d.tx_bits = 4'd10;
      d.tx_div  = baud_div - 16'd1;
    end

    // Link error aborts everything and answers with a break
    // The control register is kept across an abort
    if (flush) begin
      d.st         = dci_pkg::S_IDLE;
      d.argn       = 2'd0;
      d.nresp      = 2'd0;
      d.push       = 1'b0;
      d.reg_wr     = 1'b0;
      d.reg_rd     = 1'b0;
      d.pc_wr      = 1'b0;
      d.tx_bits    = 4'd0;
      d.brk_cnt    = `DCI_BREAK_CYC;
      d.pin_oe     = 1'b1;
      d.baud_reset = 1'b1;
    end

    d.rx_ready = (d.brk_cnt == 13'd0) &&
                 (d.st == dci_pkg::S_IDLE || d.st == dci_pkg::S_ARG || d.st == dci_pkg::S_WDATA);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q     <= '0;
      q.st  <= dci_pkg::S_IDLE;
      q.ctl <= `DCI_CTL_RST_VAL;
    end else begin
      q <= d;
    end
  end

  // Response byte buffer between decoder and transmitter
  dci_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) dci_fifo_inst (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_valid  (q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (q.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // Outputs straight from the state register
  assign rx_ready            = q.rx_ready;
  assign baud_reset          = q.baud_reset;
  assign debug_serial_pin_o  = q.pin_o;
  assign debug_serial_pin_oe = q.pin_oe;
  assign debug_control_reg   = q.ctl;
  assign reg_wr_en           = q.reg_wr;
  assign reg_rd_en           = q.reg_rd;
  assign reg_addr            = q.reg_addr;
  assign reg_wdata           = q.reg_wdata;
  assign pc_wr_en            = q.pc_wr;
  assign pc_wdata            = q.pc_wdata;

endmodule : dci_interp

// >>> bench/dci_interp_asserts.sv
/*
  Port checker of the debug command interpreter.
  Assumes binding into dci_interp and a single sys_clk domain.
*/
`timescale 1ns/1ps
module dci_interp_asserts #(
  parameter logic [11:0] FLASH_LO   = 12'hff8,
  parameter logic [11:0] FLASH_HI   = 12'hfff,
  parameter logic [11:0] FLASH_CMD  = 12'hff8,
  parameter logic [7:0]  MASS_ERASE = 8'h63
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        rx_err,
  input wire logic        baud_reset,
  input wire logic        debug_serial_pin_oe,
  input wire logic        read_protect_option,
  input wire logic [7:0]  debug_control_reg,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        pc_wr_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic [12:0] run_q;
  logic        brk_q;

  // Length of each low drive, flagged when it follows an abort
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      run_q <= 13'h0000;
      brk_q <= 1'b0;
    end else begin
      run_q <= debug_serial_pin_oe ? run_q + 13'h0001 : 13'h0000;
      brk_q <= baud_reset | (brk_q & debug_serial_pin_oe);
    end
  end

  chk_wr_in_debug: assert property (reg_wr_en |-> debug_control_reg[7])
    else $error("register write outside debug mode");
  chk_pc_wr_guard: assert property (pc_wr_en |-> debug_control_reg[7] && !read_protect_option)
    else $error("program counter write refused case");
  chk_rd_guard: assert property (reg_rd_en |-> debug_control_reg[7] && !read_protect_option)
    else $error("register read while refused");
  chk_wr_flash_only: assert property (reg_wr_en && read_protect_option |->
    reg_addr >= FLASH_LO && reg_addr <= FLASH_HI) else $error("protected write off flash");
  chk_flash_cmd: assert property (reg_wr_en && read_protect_option && reg_addr == FLASH_CMD
    |-> reg_wdata == MASS_ERASE) else $error("protected flash command not erase");
  chk_halt_sticky: assert property ($fell(debug_control_reg[7]) |-> !$past(read_protect_option))
    else $error("halt flag cleared under protection");
  chk_abort_baud: assert property (rx_err && !debug_serial_pin_oe |=> baud_reset)
    else $error("no baud reset after receive error");
  chk_break_len: assert property ($fell(debug_serial_pin_oe) && brk_q |->
    run_q >= 13'd4094 && run_q <= 13'd4097) else $error("break length wrong");
  chk_break_cap: assert property (brk_q |-> run_q <= 13'd4097)
    else $error("break too long");

  cover property (reg_wr_en && read_protect_option);
  cover property (reg_rd_en);
  cover property ($rose(baud_reset));
endmodule : dci_interp_asserts

bind dci_interp dci_interp_asserts #(
  .FLASH_LO(FLASH_LO), .FLASH_HI(FLASH_HI), .FLASH_CMD(FLASH_CMD), .MASS_ERASE(MASS_ERASE)
) dci_interp_asserts_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .rx_err(rx_err), .baud_reset(baud_reset),
  .debug_serial_pin_oe(debug_serial_pin_oe), .read_protect_option(read_protect_option),
  .debug_control_reg(debug_control_reg), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pc_wr_en(pc_wr_en)
);

// >>> bench/dci_host_model.sv
/*
  Behavioural debug host that decodes the frames sent on the pin.
  Assumes a pulled-up pin and a bit time of baud_div system clocks.
*/
`timescale 1ns/1ps
module dci_host_model (
  input  wire logic        sys_clk,
  input  wire logic        pin,
  input  wire logic [15:0] baud_div,
  output logic             got,
  output logic [7:0]       got_byte
);
  logic [7:0] sh;

  // Start bit, eight bits LSB first, stop bit; broken frames dropped
  initial begin
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(posedge sys_clk);
      got <= 1'b0;
      if (pin === 1'b0) begin
        repeat (baud_div / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (baud_div) @(posedge sys_clk);
          sh[i] = pin;
        end
        repeat (baud_div) @(posedge sys_clk);
        if (pin === 1'b1) begin
          got <= 1'b1;
          got_byte <= sh;
        end
        while (pin !== 1'b1) @(posedge sys_clk);
      end
    end
  end
endmodule : dci_host_model

// >>> bench/test_debug_command_interpreter.sv
/*
  Self-checking bench of the debug command interpreter.
  Assumes the bench stands in for the receive engine and register file.
*/
`timescale 1ns/1ps
module test_debug_command_interpreter;
  logic        sys_clk, rst_b, rx_valid, rx_err, rx_ready, baud_reset, pin_o, pin_oe, pin;
  logic        rp, cpu_halted, brk_idle, brk_halt, reset_done, reg_wr_en, reg_rd_en;
  logic        pc_wr_en, got, saw_brk, host_low;
  logic [7:0]  rx_data, ctl, reg_wdata, reg_rdata, got_byte, v;
  logic [11:0] reg_addr;
  logic [15:0] baud_div, pc_wdata, pc_rdata, w;
  logic [7:0]  exp_rx[$], dq[$], none[$];
  logic [19:0] exp_wr[$];
  logic [15:0] exp_pc[$];
  int          err_total, samples_checked, cyc, rd_n;

  assign pin = (pin_oe || host_low) ? 1'b0 : 1'b1; // Open drain with pull-up

  dci_interp dci_interp_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .rx_ready(rx_ready), .baud_reset(baud_reset), .baud_div(baud_div),
    .debug_serial_pin_i(pin), .debug_serial_pin_o(pin_o), .debug_serial_pin_oe(pin_oe),
    .read_protect_option(rp), .cpu_halted(cpu_halted), .brk_idle(brk_idle),
    .brk_halt(brk_halt), .reset_done(reset_done), .debug_control_reg(ctl),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pc_wr_en(pc_wr_en),
    .pc_wdata(pc_wdata), .pc_rdata(pc_rdata));

  dci_host_model dci_host_model_inst (
    .sys_clk(sys_clk), .pin(pin), .baud_div(baud_div), .got(got), .got_byte(got_byte));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] rf(input logic [11:0] a);
    return a[7:0] ^ {4'h0, a[11:8]} ^ 8'h3c;
  endfunction : rf

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Bytes back to back, each held until taken
  task automatic seq(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      while (rx_ready !== 1'b1) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
  endtask : seq

  task automatic rcmd(input logic [7:0] c, input logic [11:0] a, input logic [7:0] n,
                      input logic [7:0] d[$]);
    logic [7:0] q[$];
    q = '{c, {4'h0, a[11:8]}, a[7:0], n};
    q = {q, d};
    seq(q);
  endtask : rcmd

  task automatic rexp(input logic [11:0] a, input int n, input logic fill);
    for (int k = 0; k < n; k++) exp_rx.push_back(fill ? 8'hff : rf(a + 12'(k)));
  endtask : rexp

  task automatic drain;
    while (exp_rx.size() != 0 || pin_oe !== 1'b0) @(negedge sys_clk);
  endtask : drain

  // Scoreboard, register file answers and cycle ceiling
  always @(negedge sys_clk) begin
    if (got === 1'b1) begin
      if (exp_rx.size() == 0) check({12'h000, got_byte}, 20'hfffff);
      else check({12'h000, got_byte}, {12'h000, exp_rx.pop_front()});
    end
    if (reg_wr_en === 1'b1) begin
      if (exp_wr.size() == 0) check({reg_addr, reg_wdata}, 20'hfffff);
      else check({reg_addr, reg_wdata}, exp_wr.pop_front());
    end
    if (pc_wr_en === 1'b1) begin
      if (exp_pc.size() == 0) check({4'h0, pc_wdata}, 20'hfffff);
      else check({4'h0, pc_wdata}, {4'h0, exp_pc.pop_front()});
    end
    if (baud_reset === 1'b1) saw_brk = 1'b1;
    if (reg_rd_en === 1'b1) rd_n++;
    reg_rdata <= rf(reg_addr);
    cyc++;
    if (cyc > 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {rst_b, rx_valid, rx_err, rp, cpu_halted, brk_idle, brk_halt, reset_done} = 8'h00;
    {rx_data, reg_rdata, pc_rdata, saw_brk, host_low} = 34'h0;
    {err_total, samples_checked, cyc, rd_n} = '0;
    void'($urandom(32'he7abdfe1));
    baud_div = 16'd4 + 16'($urandom_range(3, 0));
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    check(20'(ctl), 20'h0);
    check(20'(pin_oe), 20'h0);
    // Normal mode
    exp_rx = '{8'h01, 8'h00};
    seq('{8'h00});
    cpu_halted = 1'($urandom);
    brk_idle = 1'($urandom);
    exp_rx.push_back({brk_idle, cpu_halted, 6'h00});
    seq('{8'h02});
    rexp(12'h000, 2, 1'b1);
    seq('{8'h07});
    rexp(12'h010, 1, 1'b1);
    rcmd(8'h09, 12'h010, 8'h01, none);
    seq('{8'h06, 8'h12, 8'h34});
    rcmd(8'h08, 12'h020, 8'h01, '{8'h55});
    v = 8'($urandom) | 8'h80;
    exp_rx.push_back(v & 8'hf1);
    seq('{8'h0f, 8'h13, 8'hff, 8'h04, v, 8'h05});
    drain();
    // Reset flag cleared, halt set from breakpoint
    seq('{8'h04, 8'h01});
    reset_done = 1'b1;
    @(negedge sys_clk);
    reset_done = 1'b0;
    brk_halt = 1'b1;
    @(negedge sys_clk);
    brk_halt = 1'b0;
    exp_rx.push_back(8'h80);
    seq('{8'h05});
    drain();
    // Debug mode, unprotected
    pc_rdata = 16'($urandom);
    exp_rx.push_back(pc_rdata[15:8]);
    exp_rx.push_back(pc_rdata[7:0]);
    seq('{8'h07});
    w = 16'($urandom);
    exp_pc.push_back(w);
    seq('{8'h06, w[15:8], w[7:0]});
    dq = none;
    for (int k = 0; k < 256; k++) begin
      v = 8'($urandom);
      dq.push_back(v);
      exp_wr.push_back({12'h0f0 + 12'(k), v});
    end
    rcmd(8'h08, 12'h0f0, 8'h00, dq);
    rexp(12'h0f0, 3, 1'b0);
    rcmd(8'h09, 12'h0f0, 8'h03, none);
    rexp(12'h200, 256, 1'b0);
    rcmd(8'h09, 12'h200, 8'h00, none);
    drain();
    // Read protection
    rp = 1'b1;
    exp_rx.push_back({2'b11 & {1'b1, cpu_halted}, 6'h20});
    exp_rx.push_back(8'h80);
    seq('{8'h02, 8'h04, 8'h00, 8'h05});
    rexp(12'h000, 2, 1'b1);
    seq('{8'h07, 8'h06, 8'h12, 8'h34});
    rexp(12'h030, 1, 1'b1);
    rcmd(8'h09, 12'h030, 8'h01, none);
    rcmd(8'h08, 12'h100, 8'h01, '{8'h77});
    rcmd(8'h08, 12'hff8, 8'h01, '{8'h12});
    v = 8'($urandom);
    exp_wr.push_back({12'hff8, 8'h63});
    exp_wr.push_back({12'hff9, v});
    rcmd(8'h08, 12'hff8, 8'h02, '{8'h63, v});
    drain();
    // Abort on receive error
    rx_err = 1'b1;
    @(negedge sys_clk);
    rx_err = 1'b0;
    while (pin_oe !== 1'b1) @(negedge sys_clk);
    check(20'(pin_o), 20'h0);
    while (pin_oe !== 1'b0) @(negedge sys_clk);
    check(20'(saw_brk), 20'h1);
    // Host holds the pin low over a released bit: collision cuts the frame
    saw_brk = 1'b0;
    seq('{8'h05});
    while (pin_oe !== 1'b1) @(negedge sys_clk);
    host_low = 1'b1;
    while (baud_reset !== 1'b1) @(negedge sys_clk);
    host_low = 1'b0;
    while (pin_oe !== 1'b0) @(negedge sys_clk);
    check(20'(saw_brk), 20'h1);
    exp_rx.push_back(8'h80);
    seq('{8'h05});
    drain();
    check(20'(exp_wr.size()), 20'h0);
    check(20'(exp_pc.size()), 20'h0);
    check(20'(rd_n), 20'd259);
    report_and_stop();
  end
endmodule : test_debug_command_interpreter
